// ==== rtl/sbp_pkg.sv ====
package sbp_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PINS_N = 6;

  // Register offsets
  localparam logic [7:0] PIN_DATA_OFS  = 8'h05;
  localparam logic [7:0] DIRECTION_OFS = 8'h85;
  localparam logic [7:0] PERIPH_EN_OFS = 8'h86;

  // Field positions
  localparam int unsigned TIMER_CLK_BIT  = 4;
  localparam int unsigned SER_SEL_BIT    = 5;
  localparam int unsigned EN_TIMER_BIT   = 0;
  localparam int unsigned EN_SERIAL_BIT  = 1;

  // Pin masks
  localparam logic [5:0] PIN_BITS_ALL = 6'h3F;

  // Reset values
  localparam logic [5:0] DIRECTION_RST = 6'h3F;
  localparam logic [5:0] LATCH_RST     = 6'h00;
  localparam logic [1:0] PERIPH_EN_RST = 2'h0;
  localparam logic [7:0] RDATA_RST     = 8'h00;

  // Taps toward the sharing peripherals
  typedef struct packed {
    logic timer_clk;
    logic serial_sel_n;
    logic timer_owned;
    logic serial_owned;
  } sbp_taps_type;

  // Pin bundle toward the board
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } sbp_pin_drive_type;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sbp_bus_req_type;

endpackage

// ==== rtl/sbp_six_bit_io_port.sv ====
// Overview of operation
// [R1] Six pins, each input or output
// [R2] Direction one releases the pin driver
// [R3] Direction zero drives the output latch
// [R4] Reads give pin levels; writes hit latches
// [R5] Writes merge into sampled pin levels
// [R6] Pin four only pulls low
// [R7] Pin four feeds timer external clock
// [R8] Pin five feeds serial slave select
// [R9] Enabled peripheral takes its pin
// [R10] Bits seven and six read zero
`timescale 1ns/10ps
module sbp_six_bit_io_port
  import sbp_pkg::*;
(
  // Clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             RESETN_I,
  // Register port
  input  wire logic [7:0]       ADDR_I,
  input  wire logic [7:0]       WDATA_I,
  input  wire logic             WR_I,
  input  wire logic             RD_I,
  output logic      [7:0]       RDATA_O,
  // Pins
  input  wire logic [5:0]       PIN_I,
  output logic      [5:0]       PIN_O,
  output logic      [5:0]       PIN_OE_O,
  // Shared peripheral taps
  output logic                  TIMER_EXT_CLK_O,
  output logic                  SERIAL_SELECT_N_O,
  output logic                  TIMER_PIN_OWNED_O,
  output logic                  SERIAL_PIN_OWNED_O
);

  // Reset synchroniser stages
  logic [1:0]        rst_sync_r;
  logic              rst_n;

  // Register bus request, bundled
  sbp_bus_req_type   bus_req;
  logic              wr_data_hit;
  logic              wr_dir_hit;
  logic              wr_en_hit;
  logic              rd_any;

  // Output latches
  logic [5:0]        latch_r;
  logic [5:0]        latch_nxt;

  // Direction bits, one means input
  logic [5:0]        direction_r;
  logic [5:0]        direction_nxt;

  // Peripheral enable bits
  logic [1:0]        periph_en_r;
  logic [1:0]        periph_en_nxt;

  // Read data path
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;

  // Pin ownership, sampling and drive
  logic [5:0]        gpio_mask;
  logic [5:0]        write_mask;
  logic [5:0]        pin_sample;
  sbp_pin_drive_type drive;

  // Peripheral taps, bundled
  sbp_taps_type      taps;

  // Decode of a register hit
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Written bits replace sampled pin levels
  function automatic logic [5:0] merge_bits(input logic [5:0] pins,
                                            input logic [5:0] data,
                                            input logic [5:0] mask);
    // Only masked bits take the new value
    merge_bits = (pins & ~mask) | (data & mask);
  endfunction

  // Six-bit register widened to the bus
  function automatic logic [7:0] widen6(input logic [5:0] v);
    widen6 = {2'h0, v};
  endfunction

  // Push-pull pin drives while output and owned
  function automatic logic push_pull_oe(input logic dir,
                                        input logic owned);
    push_pull_oe = ~dir & owned;
  endfunction

  // Open-drain pin drives only a low latch
  function automatic logic open_drain_oe(input logic dir,
                                         input logic lat,
                                         input logic owned);
    open_drain_oe = ~dir & ~lat & owned;
  endfunction

  // Whether a pin is left to general purpose use
  function automatic logic pin_is_gpio(input int         idx,
                                       input logic [1:0] en);
    case (idx)
      TIMER_CLK_BIT: begin
        pin_is_gpio = ~en[EN_TIMER_BIT];
      end
      SER_SEL_BIT: begin
        pin_is_gpio = ~en[EN_SERIAL_BIT];
      end
      default: begin
        pin_is_gpio = 1'b1;
      end
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // Hold the copy low while reset stands
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // Internal reset copy for all other flops
  assign rst_n = rst_sync_r[1];

  // Bus request bundle
  always_comb begin
    bus_req.addr  = ADDR_I;
    bus_req.wdata = WDATA_I;
    bus_req.wr    = WR_I;
    bus_req.rd    = RD_I;
  end

  // Data register write
  assign wr_data_hit = bus_req.wr & hit(bus_req.addr, PIN_DATA_OFS);

  // Direction register write
  assign wr_dir_hit  = bus_req.wr & hit(bus_req.addr, DIRECTION_OFS);

  // Enable register write
  assign wr_en_hit   = bus_req.wr & hit(bus_req.addr, PERIPH_EN_OFS);

  // Read strobe
  assign rd_any      = bus_req.rd;

  // Pins left to general purpose use
  // [R9] peripheral pin ownership
  always_comb begin
    gpio_mask = PIN_BITS_ALL;
    for (int i = 0; i < int'(PINS_N); i++) begin
      // Owned pins are never driven here
      gpio_mask[i] = pin_is_gpio(i, periph_en_r);
    end
  end

  // [R5] pin levels seen by a write
  assign pin_sample = PIN_I;

  // A byte write addresses all six bits
  assign write_mask = PIN_BITS_ALL;

  // Next latch value
  // [R5] merge with pins
  always_comb begin
    // Untouched unless written
    latch_nxt = latch_r;
    if (wr_data_hit) begin
      // [R4] writes hit latches
      latch_nxt = merge_bits(pin_sample, bus_req.wdata[5:0], write_mask);
    end
  end

  // Output latches
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      // Latches start cleared
      latch_r <= LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Next direction value, upper bits dropped
  // [R1] per pin direction
  always_comb begin
    // Hold unless written
    direction_nxt = direction_r;
    if (wr_dir_hit) begin
      // [R10] bits seven, six ignored
      direction_nxt = bus_req.wdata[5:0];
    end
  end

  // Direction register
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      // All pins start as inputs
      direction_r <= DIRECTION_RST;
    end else begin
      direction_r <= direction_nxt;
    end
  end

  // Next peripheral enable value
  always_comb begin
    // Hold unless written
    periph_en_nxt = periph_en_r;
    if (wr_en_hit) begin
      periph_en_nxt = bus_req.wdata[1:0];
    end
  end

  // Peripheral enable register
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      // Both pins start with the port
      periph_en_r <= PERIPH_EN_RST;
    end else begin
      periph_en_r <= periph_en_nxt;
    end
  end

  // Pin drivers
  always_comb begin
    // Released pins default to input
    drive.out = 6'h00;
    drive.oe  = 6'h00;
    for (int i = 0; i < int'(PINS_N); i++) begin
      if (i == int'(TIMER_CLK_BIT)) begin
        // [R6] open drain: never drive high
        drive.out[i] = 1'b0;
        drive.oe[i]  = open_drain_oe(direction_r[i], latch_r[i], gpio_mask[i]);
      end else begin
        // [R3] drive latch value
        drive.out[i] = latch_r[i];
        // [R2] direction one releases
        drive.oe[i]  = push_pull_oe(direction_r[i], gpio_mask[i]);
      end
    end
  end

  // Pin bundle to the ports
  assign PIN_O    = drive.out;
  assign PIN_OE_O = drive.oe;

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = RDATA_RST;
    if (rd_any) begin
      case (bus_req.addr)
        // [R4] read pin levels
        PIN_DATA_OFS: begin
          rdata_nxt = widen6(PIN_I);
        end
        // [R10] upper bits zero
        DIRECTION_OFS: begin
          rdata_nxt = widen6(direction_r);
        end
        // Enable register, upper bits zero
        PERIPH_EN_OFS: begin
          rdata_nxt = {6'h00, periph_en_r};
        end
        // Unmapped addresses read zero
        default: begin
          rdata_nxt = RDATA_RST;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      // Bus reads zero in reset
      rdata_r <= RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data port
  assign RDATA_O = rdata_r;

  // Peripheral tap values
  always_comb begin
    // [R7] timer clock tap
    taps.timer_clk    = PIN_I[TIMER_CLK_BIT];
    // [R8] serial select tap
    taps.serial_sel_n = PIN_I[SER_SEL_BIT];
    // [R9] ownership flags
    taps.timer_owned  = periph_en_r[EN_TIMER_BIT];
    taps.serial_owned = periph_en_r[EN_SERIAL_BIT];
  end

  // Taps to the ports
  assign TIMER_EXT_CLK_O    = taps.timer_clk;
  assign SERIAL_SELECT_N_O  = taps.serial_sel_n;
  assign TIMER_PIN_OWNED_O  = taps.timer_owned;
  assign SERIAL_PIN_OWNED_O = taps.serial_owned;

endmodule

// ==== tb/sbp_port_sva.sv ====
`timescale 1ns/10ps
module sbp_port_sva
  import sbp_pkg::*;
(
  input wire logic       MCLK_I, RESETN_I, WR_I, RD_I, TIMER_EXT_CLK_O,
  input wire logic       SERIAL_SELECT_N_O, TIMER_PIN_OWNED_O, SERIAL_PIN_OWNED_O,
  input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O,
  input wire logic [5:0] PIN_I, PIN_O, PIN_OE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // Data register accesses
  sequence rd_data; RD_I && ADDR_I == PIN_DATA_OFS; endsequence
  sequence wr_data; WR_I && ADDR_I == PIN_DATA_OFS; endsequence
  a_read_pins: assert property (rd_data |=> RDATA_O == {2'h0, $past(PIN_I)}) else $error("read");
  a_top_zero: assert property (RDATA_O[7:6] == 2'h0) else $error("top");
  a_write_latch: assert property (wr_data |=> PIN_O[3:0] == $past(WDATA_I[3:0])) else $error("wr");
  a_open_drain: assert property (PIN_OE_O[4] |-> !PIN_O[4]) else $error("od");
  a_timer_tap: assert property (TIMER_EXT_CLK_O == PIN_I[4]) else $error("tck");
  a_select_tap: assert property (SERIAL_SELECT_N_O == PIN_I[5]) else $error("sel");
  a_timer_owns: assert property (TIMER_PIN_OWNED_O |-> !PIN_OE_O[4]) else $error("to");
  a_serial_owns: assert property (SERIAL_PIN_OWNED_O |-> !PIN_OE_O[5]) else $error("so");
endmodule
bind sbp_six_bit_io_port sbp_port_sva i_sva (.*);

// ==== tb/sbp_pin_board.sv ====
`timescale 1ns/10ps
// Board: pull-ups on every pin plus optional outside drivers
module sbp_pin_board (
  input  wire logic [5:0] pin_out_i, pin_oe_i, ext_val_i, ext_en_i,
  output logic      [5:0] pin_level_o
);
  // Device driver, else outside driver, else pull-up
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i) | (~pin_oe_i & ~ext_en_i);
endmodule

// ==== tb/tb_sbp_six_bit_io_port.sv ====
`timescale 1ns/10ps
module tb_sbp_six_bit_io_port;
  import sbp_pkg::*;
  logic       MCLK_I = 1'b0, RESETN_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
  logic       TIMER_EXT_CLK_O, SERIAL_SELECT_N_O, TIMER_PIN_OWNED_O, SERIAL_PIN_OWNED_O;
  logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, RDATA_O;
  logic [5:0] PIN_I, PIN_O, PIN_OE_O, ext_val = 6'h00, ext_en = 6'h00;
  int         n_errors = 0, checks = 0;
  initial forever #2.5 MCLK_I = ~MCLK_I;
  sbp_six_bit_io_port i_dut (.*);
  sbp_pin_board i_board (.pin_out_i(PIN_O), .pin_oe_i(PIN_OE_O), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .pin_level_o(PIN_I));
  task automatic chk(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= d;
    @(posedge MCLK_I) WR_I <= 1'b0;
    @(posedge MCLK_I);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    RD_I <= 1'b1; ADDR_I <= a;
    @(posedge MCLK_I) RD_I <= 1'b0;
    #1 chk(RDATA_O, exp);
    @(posedge MCLK_I);
  endtask
  task automatic close_out;
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #5000 n_errors++;
    close_out;
  end
  // Register sequence
  initial begin
    repeat (3) @(posedge MCLK_I);
    RESETN_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    rd(DIRECTION_OFS, 8'h3F);
    ext_en <= 6'h3F; ext_val <= 6'h2A;
    rd(PIN_DATA_OFS, 8'h2A);
    chk({6'h00, TIMER_EXT_CLK_O, SERIAL_SELECT_N_O}, 8'h01);
    ext_val <= 6'h15;
    rd(PIN_DATA_OFS, 8'h15);
    chk({6'h00, TIMER_EXT_CLK_O, SERIAL_SELECT_N_O}, 8'h02);
    ext_en <= 6'h00;
    wr(DIRECTION_OFS, 8'hC0);
    rd(DIRECTION_OFS, 8'h00);
    wr(PIN_DATA_OFS, 8'hFF);
    rd(PIN_DATA_OFS, 8'h3F);
    chk({2'h0, PIN_OE_O}, 8'h2F);
    chk({2'h0, PIN_O}, 8'h2F);
    wr(PIN_DATA_OFS, 8'hC5);
    rd(PIN_DATA_OFS, 8'h05);
    chk({2'h0, PIN_OE_O}, 8'h3F);
    chk({2'h0, PIN_O}, 8'h05);
    wr(PERIPH_EN_OFS, 8'h03);
    chk({2'h0, PIN_OE_O}, 8'h0F);
    chk({6'h00, TIMER_PIN_OWNED_O, SERIAL_PIN_OWNED_O}, 8'h03);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(DIRECTION_OFS, 8'hFF);
    chk({2'h0, PIN_OE_O}, 8'h00);
    rd(PIN_DATA_OFS, 8'h3F);
    $display("Port tests done");
    close_out;
  end
endmodule
